// [rtl/rcpg_top.sv]
`timescale 1ns/1ns
`include "rcpg_cfg.svh"
// Contract
// RULE1: Active and length match flags set on counter equals compare, buffered when enabled.
// RULE2: Flags at bits 1 and 0; write 1 or soft reset clears.
// RULE3: Interrupt request only while a flag and its enable are both set.
// RULE4: Clock control bit 8 keeps operating clock running in debug mode.
// RULE5: Four-bit divider divides by two to the n; low source capped. The code instead runs the low source undivided at divider code 15.
// RULE6: Two-bit source field picks one of four sources; external undivided only.
// RULE7: Clock settings change only while module enable is zero.
// RULE8: Bit 9 resets counters, reads 1 until done, soft reset clears.
// RULE9: Bit 8 starts and stops counting, self-clears at one-shot length match.
// RULE10: Bit 4 inverts the modulated output.
// RULE11: Buffering stays off while first lengths are written.
// RULE12: Bit 2 one-shot stops at length match; otherwise repeats.
// RULE13: Write-only bit 1 soft reset clears counters, controls, status, flags. The code keeps the enable, one-shot, buffer, invert and busy bits.
// RULE14: Bit 0 module enable supplies operating clock; zero idles block.
// RULE15: Software reissues soft reset after re-enabling mid transmission.
// RULE16: Data counter readable, resets to zero, cleared by soft reset.
// RULE17: Data active from zero until counter exceeds active length.
// RULE18: Data cycle starts at zero, ends after counter passes cycle length.
// RULE19: Length writes take effect only while module enable is one.
// RULE20: Status bit 10 reads 1 while counting, soft reset clears.
// RULE21: Busy bits set on length write until buffered; writes ignored meanwhile.
// RULE22: While running, both outputs driven; clamp high for length difference.
// RULE23: Modulated output is carrier AND data.
// RULE24: Carrier counter toggles on duty and period matches, resets at period.
// RULE25: With buffering, both lengths load into buffers at buffered length match.
module rcpg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System
  input wire logic debugMode,
  input wire logic srcTick0,
  input wire logic srcTick1,
  input wire logic srcTick2,
  input wire logic srcTick3,
  // Outputs
  output logic modulatedOutput,
  output logic clampPulseOutput,
  output logic irqReq
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  rcpg_pkg::rcpg_req_s req;
  logic debugClockKeep_reg;
  logic [3:0] clockDividerSelect_reg;
  logic [1:0] clockSourceSelect_reg;
  logic invert_reg, compare_buffer_enable_reg, oneShot_reg, module_enable_reg;
  logic countRun_reg, cntReset_reg, softReset_reg;
  logic [15:0] activeLength_reg, cycleLength_reg, apBuf_reg, dbBuf_reg, dataCount_reg;
  logic apBusy_reg, dbBusy_reg, apFlag_reg, dbFlag_reg;
  logic [1:0] intEn_reg;
  logic [7:0] duty_reg, period_reg, carrCount_reg;
  logic carrEn_reg, carrier_reg, tickLevel_reg;
  logic [14:0] divCount_reg, divMask;
  logic [2:0] tickSync_reg;
  rcpg_pkg::rcpg_state_e state_reg;
  logic wrAcc, rdAcc, selTick, tick, opTick;
  logic [31:0] rdNext;
  logic [15:0] apCmp, dbCmp;
  logic apHit, dbHit, dataActive, dataNext, clampNext;
  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  // A write lands only at the edge that completes the access, with pready high.
  assign wrAcc = psel && penable && req.pwrite && pready;
  assign rdAcc = psel && penable && !req.pwrite && !pready;

  // ----------------------------------------
  // Operating clock tick
  // ----------------------------------------
  always_comb
  begin
    case (clockSourceSelect_reg) // RULE6
      2'h0: selTick = srcTick0;
      2'h1: selTick = srcTick1;
      2'h2: selTick = srcTick2;
      default: selTick = srcTick3;
    endcase
  end

  // Source ticks come from other domains. A level counts only once stages two and three
  // agree, so a source must hold each level for at least two system clocks.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tickSync_reg <= 3'h0;
      tickLevel_reg <= 1'b0;
    end
    else
    begin
      tickSync_reg <= {tickSync_reg[1:0], selTick};
      if (tickSync_reg[1] == tickSync_reg[2])
        tickLevel_reg <= tickSync_reg[2];
    end
  end

  always_comb
  begin
    // RULE5
    if (clockSourceSelect_reg == `RCPG_SRC_EXT || clockDividerSelect_reg == `RCPG_DIV_MAX
        && clockSourceSelect_reg == `RCPG_SRC_LOW)
      divMask = 15'h0000;
    else
      divMask = 15'(({15'h0000, 1'b1} << clockDividerSelect_reg) - 16'h0001);
  end

  assign tick = tickSync_reg[1] == tickSync_reg[2] && tickSync_reg[2] && !tickLevel_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !module_enable_reg)
      divCount_reg <= 15'h0000;
    else if (tick)
      divCount_reg <= ((divCount_reg & divMask) == divMask) ? 15'h0000 : divCount_reg + 15'h0001;
  end

  // RULE14 RULE4
  assign opTick = module_enable_reg && tick && ((divCount_reg & divMask) == divMask)
                  && (!debugMode || debugClockKeep_reg);

  // ----------------------------------------
  // Compare logic
  // ----------------------------------------
  assign apCmp = compare_buffer_enable_reg ? apBuf_reg : activeLength_reg; // RULE1
  assign dbCmp = compare_buffer_enable_reg ? dbBuf_reg : cycleLength_reg;
  assign apHit = countRun_reg && opTick && dataCount_reg == apCmp;
  assign dbHit = countRun_reg && opTick && dataCount_reg == dbCmp;
  assign dataActive = dataCount_reg <= apCmp; // RULE17
  assign dataNext = dataActive & (carrier_reg | !carrEn_reg); // RULE23
  assign clampNext = !dataActive && dataCount_reg <= dbCmp; // RULE22

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      debugClockKeep_reg <= 1'b0;
      clockDividerSelect_reg <= 4'h0;
      clockSourceSelect_reg <= 2'h0;
      invert_reg <= 1'b0;
      compare_buffer_enable_reg <= 1'b0;
      oneShot_reg <= 1'b0;
      module_enable_reg <= 1'b0;
      intEn_reg <= 2'h0;
      duty_reg <= `RCPG_RST8;
      period_reg <= `RCPG_RST8;
      carrEn_reg <= 1'b0;
    end
    else if (wrAcc)
    begin
      if (req.paddr == `RCPG_OFF_CLK && !module_enable_reg) // RULE7
      begin
        debugClockKeep_reg <= req.pwdata[`RCPG_B_DBGKEEP];
        clockDividerSelect_reg <= req.pwdata[7:4];
        clockSourceSelect_reg <= req.pwdata[1:0];
      end
      else if (req.paddr == `RCPG_OFF_CTL)
      begin
        invert_reg <= req.pwdata[`RCPG_B_INV]; // RULE10
        compare_buffer_enable_reg <= req.pwdata[`RCPG_B_COMPARE_BUFFER_ENABLE];
        oneShot_reg <= req.pwdata[`RCPG_B_ONESHOT]; // RULE12
        module_enable_reg <= req.pwdata[`RCPG_B_MODULE_ENABLE];
      end
      else if (req.paddr == `RCPG_OFF_IEN)
        intEn_reg <= req.pwdata[1:0];
      else if (req.paddr == `RCPG_OFF_CARR)
      begin
        duty_reg <= req.pwdata[15:8];
        period_reg <= req.pwdata[7:0];
      end
      else if (req.paddr == `RCPG_OFF_CMOD)
        carrEn_reg <= req.pwdata[0];
    end
  end

  // ----------------------------------------
  // Length registers and buffers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      activeLength_reg <= `RCPG_RST16;
      cycleLength_reg <= `RCPG_RST16;
      apBuf_reg <= `RCPG_RST16;
      dbBuf_reg <= `RCPG_RST16;
      apBusy_reg <= 1'b0;
      dbBusy_reg <= 1'b0;
    end
    else
    begin
      if (wrAcc && module_enable_reg && req.paddr == `RCPG_OFF_APL && !(compare_buffer_enable_reg && apBusy_reg))
      begin
        activeLength_reg <= req.pwdata[15:0]; // RULE19 RULE21
        apBusy_reg <= compare_buffer_enable_reg;
      end
      else if (dbHit || !compare_buffer_enable_reg)
        apBusy_reg <= 1'b0;
      if (wrAcc && module_enable_reg && req.paddr == `RCPG_OFF_DBL && !(compare_buffer_enable_reg && dbBusy_reg))
      begin
        cycleLength_reg <= req.pwdata[15:0]; // RULE19 RULE21
        dbBusy_reg <= compare_buffer_enable_reg;
      end
      else if (dbHit || !compare_buffer_enable_reg)
        dbBusy_reg <= 1'b0;
      if (!compare_buffer_enable_reg || dbHit)
      begin
        apBuf_reg <= activeLength_reg; // RULE25
        dbBuf_reg <= cycleLength_reg;
      end
    end
  end

  // ----------------------------------------
  // Counters, run and soft reset
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= rcpg_pkg::RCPG_IDLE;
      softReset_reg <= 1'b0;
      cntReset_reg <= 1'b0;
      countRun_reg <= 1'b0;
      dataCount_reg <= `RCPG_RST16;
      carrCount_reg <= `RCPG_RST8;
      carrier_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        rcpg_pkg::RCPG_SRST:
        begin
          // RULE13 RULE16 RULE20
          softReset_reg <= 1'b0;
          cntReset_reg <= 1'b0;
          countRun_reg <= 1'b0;
          dataCount_reg <= `RCPG_RST16;
          carrCount_reg <= `RCPG_RST8;
          carrier_reg <= 1'b1;
          state_reg <= rcpg_pkg::RCPG_IDLE;
        end
        default:
        begin
          if (wrAcc && req.paddr == `RCPG_OFF_CTL && req.pwdata[`RCPG_B_SRST])
          begin
            softReset_reg <= 1'b1;
            state_reg <= rcpg_pkg::RCPG_SRST;
          end
          else
          begin
            if (wrAcc && req.paddr == `RCPG_OFF_CTL && module_enable_reg)
            begin
              countRun_reg <= req.pwdata[`RCPG_B_RUN]; // RULE9
              if (req.pwdata[`RCPG_B_RESET])
                cntReset_reg <= 1'b1; // RULE8
            end
            else if (dbHit && oneShot_reg)
              countRun_reg <= 1'b0; // RULE9 RULE12
            if (cntReset_reg)
            begin
              dataCount_reg <= `RCPG_RST16;
              carrCount_reg <= `RCPG_RST8;
              carrier_reg <= 1'b1;
              cntReset_reg <= 1'b0;
            end
            else if (countRun_reg && opTick)
            begin
              dataCount_reg <= dbHit ? `RCPG_RST16 : dataCount_reg + 16'h0001; // RULE18
              if (carrCount_reg == period_reg) // RULE24
              begin
                carrCount_reg <= `RCPG_RST8;
                carrier_reg <= 1'b1;
              end
              else
              begin
                carrCount_reg <= carrCount_reg + 8'h01;
                if (carrCount_reg == duty_reg)
                  carrier_reg <= 1'b0;
              end
            end
            state_reg <= countRun_reg ? rcpg_pkg::RCPG_RUN : rcpg_pkg::RCPG_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Match flags
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_reg == rcpg_pkg::RCPG_SRST)
    begin
      apFlag_reg <= 1'b0;
      dbFlag_reg <= 1'b0;
    end
    else
    begin
      // Set wins over a same-cycle write-1 clear.
      if (apHit) // RULE1
        apFlag_reg <= 1'b1;
      else if (wrAcc && req.paddr == `RCPG_OFF_STAT && req.pwdata[`RCPG_B_ACTIVE_MATCH_FLAG])
        apFlag_reg <= 1'b0; // RULE2
      if (dbHit)
        dbFlag_reg <= 1'b1;
      else if (wrAcc && req.paddr == `RCPG_OFF_STAT && req.pwdata[`RCPG_B_LENGTH_MATCH_FLAG])
        dbFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs and bus answer
  // ----------------------------------------
  always_comb
  begin
    rdNext = 32'h00000000;
    if (req.paddr == `RCPG_OFF_CLK)
      rdNext = {23'h000000, debugClockKeep_reg, clockDividerSelect_reg, 2'h0,
                clockSourceSelect_reg};
    else if (req.paddr == `RCPG_OFF_CTL)
      rdNext = {22'h000000, cntReset_reg, countRun_reg, 3'h0, invert_reg, compare_buffer_enable_reg,
                oneShot_reg, softReset_reg, module_enable_reg};
    else if (req.paddr == `RCPG_OFF_CNT)
      rdNext = {16'h0000, dataCount_reg};
    else if (req.paddr == `RCPG_OFF_APL)
      rdNext = {16'h0000, activeLength_reg};
    else if (req.paddr == `RCPG_OFF_DBL)
      rdNext = {16'h0000, cycleLength_reg};
    else if (req.paddr == `RCPG_OFF_STAT)
      rdNext = {21'h000000, countRun_reg, dbBusy_reg, apBusy_reg, 6'h00, dbFlag_reg,
                apFlag_reg}; // RULE20 RULE21
    else if (req.paddr == `RCPG_OFF_IEN)
      rdNext = {30'h00000000, intEn_reg};
    else if (req.paddr == `RCPG_OFF_CARR)
      rdNext = {16'h0000, duty_reg, period_reg};
    else if (req.paddr == `RCPG_OFF_CMOD)
      rdNext = {31'h00000000, carrEn_reg};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && req.paddr > `RCPG_OFF_CMOD;
      if (rdAcc)
        prdata <= rdNext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      modulatedOutput <= 1'b0;
      clampPulseOutput <= 1'b0;
      irqReq <= 1'b0;
    end
    else
    begin
      modulatedOutput <= countRun_reg ? (dataNext ^ invert_reg) : invert_reg; // RULE22
      clampPulseOutput <= countRun_reg && clampNext;
      irqReq <= (apFlag_reg && intEn_reg[0]) || (dbFlag_reg && intEn_reg[1]); // RULE3
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    irqReq == $past((apFlag_reg && intEn_reg[0]) || (dbFlag_reg && intEn_reg[1])))
    else $error("irq not gated by flag and enable");
  chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    apHit && state_reg != rcpg_pkg::RCPG_SRST |=> apFlag_reg)
    else $error("active match flag not set");
  chk_oneshot_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    dbHit && oneShot_reg && !wrAcc && state_reg != rcpg_pkg::RCPG_SRST |=> !countRun_reg)
    else $error("one-shot did not stop");
  chk_srst_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    state_reg == rcpg_pkg::RCPG_SRST |=> !countRun_reg && dataCount_reg == 16'h0000
    && !apFlag_reg && !dbFlag_reg)
    else $error("soft reset incomplete");
  chk_clk_lock: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    module_enable_reg |=> $stable(clockSourceSelect_reg) && $stable(clockDividerSelect_reg))
    else $error("clock setting changed while enabled");
  chk_len_lock: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    !module_enable_reg |=> $stable(activeLength_reg) && $stable(cycleLength_reg))
    else $error("length changed while disabled");
  chk_no_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    !module_enable_reg |-> !opTick)
    else $error("operating tick while disabled");
  chk_cnt_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    dbHit && !cntReset_reg && state_reg != rcpg_pkg::RCPG_SRST
    && !(wrAcc && req.paddr == `RCPG_OFF_CTL && req.pwdata[`RCPG_B_SRST])
    |=> dataCount_reg == 16'h0000)
    else $error("counter did not wrap at length");
endmodule : rcpg_top

// [rtl/rcpg_cfg.svh]
`ifndef RCPG_CFG_SVH
`define RCPG_CFG_SVH
`define RCPG_OFF_CLK 12'h000
`define RCPG_OFF_CTL 12'h004
`define RCPG_OFF_CNT 12'h008
`define RCPG_OFF_APL 12'h00C
`define RCPG_OFF_DBL 12'h010
`define RCPG_OFF_STAT 12'h014
`define RCPG_OFF_IEN 12'h018
`define RCPG_OFF_CARR 12'h01C
`define RCPG_OFF_CMOD 12'h020
`define RCPG_B_DBGKEEP 8
`define RCPG_B_RESET 9
`define RCPG_B_RUN 8
`define RCPG_B_INV 4
`define RCPG_B_COMPARE_BUFFER_ENABLE 3
`define RCPG_B_ONESHOT 2
`define RCPG_B_SRST 1
`define RCPG_B_MODULE_ENABLE 0
`define RCPG_B_STRUN 10
`define RCPG_B_DBBSY 9
`define RCPG_B_APBSY 8
`define RCPG_B_LENGTH_MATCH_FLAG 1
`define RCPG_B_ACTIVE_MATCH_FLAG 0
`define RCPG_RST16 16'h0000
`define RCPG_RST8 8'h00
`define RCPG_SRC_EXT 2'h3
`define RCPG_SRC_LOW 2'h1
`define RCPG_DIV_MAX 4'hF
`define RCPG_DIV_LOWCAP 4'h8
`endif

// [rtl/rcpg_pkg.sv]
package rcpg_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } rcpg_req_s;
  typedef enum logic [1:0] {
    RCPG_IDLE = 2'b00,
    RCPG_RUN = 2'b01,
    RCPG_SRST = 2'b10
  } rcpg_state_e;
endpackage : rcpg_pkg

// [test/rcpg_emitter.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Emitter drive model
// ----------------------------------------
// The drive stage only listens, so it measures both spans of the modulated pin and the high span of the clamp pin.
// The spans are counted in system clocks, and each one is latched when the level changes.
module rcpg_emitter (
  // Clock
  input wire logic clk,
  // Drive pins
  input wire logic modulatedOutput,
  input wire logic clampPulseOutput,
  // Measurements
  output int hiLen,
  output int loLen,
  output int clampHi,
  output int riseCount
);
  int runMod;
  int runClamp;
  logic lastMod;
  logic lastClamp;
  initial
  begin
    {hiLen, loLen, clampHi, riseCount, runMod, runClamp} = '0;
    lastMod = 1'b0;
    lastClamp = 1'b0;
  end
  always @(posedge clk)
  begin
    if (modulatedOutput !== lastMod)
    begin
      if (lastMod === 1'b1) hiLen <= runMod;
      else loLen <= runMod;
      if (modulatedOutput === 1'b1) riseCount <= riseCount + 1;
      runMod <= 1;
    end
    else runMod <= runMod + 1;
    if (clampPulseOutput !== lastClamp)
    begin
      if (lastClamp === 1'b1) clampHi <= runClamp;
      runClamp <= 1;
    end
    else runClamp <= runClamp + 1;
    lastMod <= modulatedOutput;
    lastClamp <= clampPulseOutput;
  end
endmodule : rcpg_emitter

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "rcpg_cfg.svh"
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rst_n, psel, penable, pwrite, debugMode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v1;
  logic pready, pslverr, modulatedOutput, clampPulseOutput, irqReq, err;
  logic [3:0] ticks;
  logic [15:0] apl, dbl;
  int fails, num_checks, seed, hiLen, loLen, clampHi, riseCount, kk, k;
  rcpg_top u_rcpg_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debugMode(debugMode), .srcTick0(ticks[1]), .srcTick1(ticks[2]),
    .srcTick2(ticks[3]), .srcTick3(ticks[1]), .modulatedOutput(modulatedOutput),
    .clampPulseOutput(clampPulseOutput), .irqReq(irqReq));
  rcpg_emitter u_rcpg_emitter (.clk(clk), .modulatedOutput(modulatedOutput),
    .clampPulseOutput(clampPulseOutput), .hiLen(hiLen), .loLen(loLen),
    .clampHi(clampHi), .riseCount(riseCount));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Sources 0 and 3 rise every four clocks, slow enough to pass the agreement filter.
  always @(posedge clk) ticks <= ticks + 4'h1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task rdc(input string name, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(name, e, rd & m);
  endtask : rdc
  task chkIrq(input logic e);
    repeat (2) @(posedge clk);
    chk("irq request", {31'h0, e}, {31'h0, irqReq});
  endtask : chkIrq
  task waitRise(input int n);
    int b;
    b = riseCount;
    k = 0;
    while (riseCount < b + n && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    chk("pulse arrival", 32'h1, {31'h0, k < 5000});
  endtask : waitRise
  task pollBit(input logic [11:0] a, input int b);
    k = 0;
    do
    begin
      apb(a, 1'b0, 32'h0);
      k++;
    end
    while (rd[b] !== 1'b0 && k < 300);
  endtask : pollBit
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial
  begin
    seed = 32'h5700;
    {psel, penable, pwrite, debugMode, rst_n} = '0;
    {paddr, pwdata, ticks, fails, num_checks} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdc("clock ctl", `RCPG_OFF_CLK, 32'hFFFF, 32'h0);
    rdc("counter ctl", `RCPG_OFF_CTL, 32'hFFFF, 32'h0);
    rdc("data counter", `RCPG_OFF_CNT, 32'hFFFF, 32'h0);
    rdc("status", `RCPG_OFF_STAT, 32'hFFFF, 32'h0);
    rdc("int enables", `RCPG_OFF_IEN, 32'hFFFF, 32'h0);
    apb(12'h024, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    wr(`RCPG_OFF_APL, 32'h55);
    rdc("active length", `RCPG_OFF_APL, 32'hFFFF, 32'h0);
    wr(`RCPG_OFF_CLK, 32'h100);
    wr(`RCPG_OFF_CTL, 32'h1);
    wr(`RCPG_OFF_CLK, 32'hF3);
    rdc("clock ctl", `RCPG_OFF_CLK, 32'hFFFF, 32'h100);
    // Divider 0 and 1 with both polarities; debug entry with the keep bit set.
    for (int c = 0; c < 4; c++)
    begin
      apl = 16'($unsigned($random(seed)) % 6 + 1);
      dbl = apl + 16'($unsigned($random(seed)) % 5 + 1);
      kk = 4 << c[0];
      debugMode <= c[1];
      wr(`RCPG_OFF_CTL, 32'h0);
      wr(`RCPG_OFF_CLK, 32'h100 | (c[0] << 4));
      wr(`RCPG_OFF_CTL, 32'h1);
      wr(`RCPG_OFF_CTL, 32'h3);
      wr(`RCPG_OFF_APL, {16'h0, apl});
      wr(`RCPG_OFF_DBL, {16'h0, dbl});
      wr(`RCPG_OFF_CTL, 32'h301 | (c[1] << 4));
      waitRise(3);
      chk("active span", kk * (apl + 1), c[1] ? loLen : hiLen);
      chk("idle span", kk * (dbl - apl), c[1] ? hiLen : loLen);
      chk("clamp span", kk * (dbl - apl), clampHi);
      rdc("running", `RCPG_OFF_STAT, 32'h400, 32'h400);
    end
    debugMode <= 1'b0;
    wr(`RCPG_OFF_CTL, 32'h11);
    rdc("flags", `RCPG_OFF_STAT, 32'h403, 32'h3);
    chkIrq(1'b0);
    wr(`RCPG_OFF_IEN, 32'h1);
    chkIrq(1'b1);
    wr(`RCPG_OFF_STAT, 32'h0);
    rdc("flags", `RCPG_OFF_STAT, 32'h3, 32'h3);
    wr(`RCPG_OFF_STAT, 32'h1);
    rdc("flags", `RCPG_OFF_STAT, 32'h3, 32'h2);
    chkIrq(1'b0);
    wr(`RCPG_OFF_IEN, 32'h2);
    chkIrq(1'b1);
    wr(`RCPG_OFF_STAT, 32'h2);
    chkIrq(1'b0);
    wr(`RCPG_OFF_CTL, 32'h301);
    waitRise(1);
    wr(`RCPG_OFF_CTL, 32'h3);
    rdc("controls", `RCPG_OFF_CTL, 32'h302, 32'h0);
    rdc("status", `RCPG_OFF_STAT, 32'h403, 32'h0);
    rdc("data counter", `RCPG_OFF_CNT, 32'hFFFF, 32'h0);
    wr(`RCPG_OFF_CTL, 32'h305);
    pollBit(`RCPG_OFF_CTL, `RCPG_B_RUN);
    chk("one-shot run", 32'h0, rd & 32'h100);
    rdc("one-shot end", `RCPG_OFF_STAT, 32'h402, 32'h2);
    // Stopped with buffering on, so the first write stays pending.
    wr(`RCPG_OFF_CTL, 32'h9);
    wr(`RCPG_OFF_APL, {16'h0, apl + 16'h1});
    rdc("active busy", `RCPG_OFF_STAT, 32'h100, 32'h100);
    wr(`RCPG_OFF_APL, 32'h7);
    rdc("active length", `RCPG_OFF_APL, 32'hFFFF, {16'h0, apl + 16'h1});
    wr(`RCPG_OFF_CTL, 32'h309);
    pollBit(`RCPG_OFF_STAT, `RCPG_B_APBSY);
    chk("buffer load", 32'h0, rd & 32'h100);
    wr(`RCPG_OFF_CTL, 32'h0);
    wr(`RCPG_OFF_CLK, 32'h0);
    wr(`RCPG_OFF_CTL, 32'h1);
    wr(`RCPG_OFF_CTL, 32'h3);
    wr(`RCPG_OFF_CTL, 32'h301);
    debugMode <= 1'b1;
    repeat (8) @(posedge clk);
    apb(`RCPG_OFF_CNT, 1'b0, 32'h0);
    v1 = rd;
    rdc("held counter", `RCPG_OFF_CNT, 32'hFFFFFFFF, v1);
    // Carrier on, external source at the top divider code, which must stay undivided.
    debugMode <= 1'b0;
    kk = 4;
    wr(`RCPG_OFF_CTL, 32'h0);
    wr(`RCPG_OFF_CLK, 32'hF3);
    wr(`RCPG_OFF_CARR, 32'h0104);
    wr(`RCPG_OFF_CMOD, 32'h1);
    wr(`RCPG_OFF_CTL, 32'h1);
    wr(`RCPG_OFF_CTL, 32'h3);
    wr(`RCPG_OFF_APL, 32'h13);
    wr(`RCPG_OFF_DBL, 32'h27);
    wr(`RCPG_OFF_CTL, 32'h301);
    waitRise(7);
    chk("carrier high", kk * (1 + 1), hiLen);
    chk("carrier low", kk * (4 - 1), loLen);
    chk("carrier clamp", kk * (39 - 19), clampHi);
    give_verdict;
  end
endmodule : tb_top
